// ==== rtl/lcd_master_slave_sync.sv ====
`timescale 1ns/1ps
`include "lcd_sync_params.svh"

module lcd_master_slave_sync #(
  parameter int OSC_PER_HALF_LINE = `LCD_OSC_PER_HALF_LINE,
  parameter int STRAP_SETTLE = `LCD_STRAP_SETTLE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Board straps and duty
  input wire logic master_strap,
  input wire logic duty_32,
  // Oscillator pins
  input wire logic oscillator_in_pin,
  input wire logic oscillator_out_pin_in,
  output logic oscillator_out_pin_out,
  output logic oscillator_out_pin_oe,
  // Frame polarity pin
  input wire logic frame_polarity_in,
  output logic frame_polarity_out,
  output logic frame_polarity_oe,
  // Line clock pin
  input wire logic line_clock_in,
  output logic line_clock_out,
  output logic line_clock_oe,
  // Panel side
  output logic [`LCD_ROWS_PER_CHIP-1:0] row_drive_outputs,
  output logic drive_polarity,
  output logic is_master
);
  import lcd_sync_pkg::*;

  localparam int CW = $clog2(OSC_PER_HALF_LINE + 1) + 1;
  // Synchroniser flops come out of reset low, so the settle count starts after them
  localparam int SETTLE_END = STRAP_SETTLE + `LCD_SYNC_STAGES;
  localparam int SW = $clog2(SETTLE_END + 1) + 1;

  role_state_t state;
  row_index_t row_idx;
  row_index_t next_row;
  logic [SW-1:0] settle_cnt;
  logic [CW-1:0] osc_cnt;
  logic line_fall;
  logic fr_pending;
  logic next_frame;
  logic [4:0] s_level;
  logic [4:0] s_rise;
  logic [4:0] s_fall;
  logic strap_s;
  logic osc_in_s;
  logic osc_rise;
  logic fr_edge;
  logic cl_fall;
  logic [4:0] last_row;

  // Maps a panel row to this chip's row drivers
  function automatic logic [`LCD_ROWS_PER_CHIP-1:0] row_bits(input row_index_t idx,
                                                           input logic slave);
    logic [`LCD_ROWS_PER_CHIP-1:0] bits;
    bits = '0;
    if (!slave && idx < 5'(`LCD_ROWS_PER_CHIP)) begin
      bits[idx[3:0]] = 1'b1;
    end else if (slave && idx >= 5'(`LCD_ROWS_PER_CHIP)) begin
      // Reversed: first slave row sits on the top driver
      bits[4'hF - idx[3:0]] = 1'b1;
    end
    return bits;
  endfunction : row_bits

  // All pins from outside except duty_32 pass two flip-flops
  pin_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({master_strap, oscillator_in_pin, oscillator_out_pin_in,
          frame_polarity_in, line_clock_in}),
    .level(s_level),
    .rise(s_rise),
    .fall(s_fall)
  );

  assign strap_s = s_level[4];
  assign osc_in_s = s_level[3];
  assign osc_rise = s_rise[3];
  assign fr_edge = s_rise[1] | s_fall[1];
  assign cl_fall = s_fall[0];
  assign last_row = duty_32 ? 5'(`LCD_DUTY32_ROWS - 1) : 5'(`LCD_DUTY16_ROWS - 1);

  // Role capture after release; the strap is never looked at again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SETTLE;
      settle_cnt <= '0;
    end else begin
      case (state)
        ST_SETTLE: begin
          if (settle_cnt == SW'(SETTLE_END)) begin
            state <= strap_s ? ST_MASTER : ST_SLAVE;
          end else begin
            settle_cnt <= settle_cnt + 1'b1;
          end
        end
        ST_MASTER: state <= ST_MASTER;
        ST_SLAVE: state <= ST_SLAVE;
        default: state <= ST_SETTLE;
      endcase
    end
  end

  // Master line clock from oscillator edges; a fall of the output marks the line step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= '0;
      line_clock_out <= 1'b0;
      line_fall <= 1'b0;
    end else begin
      line_fall <= 1'b0;
      if (state == ST_MASTER && osc_rise) begin
        if (osc_cnt == CW'(OSC_PER_HALF_LINE - 1)) begin
          osc_cnt <= '0;
          line_clock_out <= ~line_clock_out;
          line_fall <= line_clock_out;
        end else begin
          osc_cnt <= osc_cnt + 1'b1;
        end
      end
    end
  end

  // Pending frame edge; the line step clears it even when a new edge comes in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_pending <= 1'b0;
    end else if (fr_edge) begin
      fr_pending <= !cl_fall;
    end else if (cl_fall) begin
      fr_pending <= 1'b0;
    end
  end

  // Next row and frame level per role
  always_comb begin
    next_row = row_idx;
    next_frame = frame_polarity_out;
    if (state == ST_MASTER) begin
      if (line_fall) begin
        if (row_idx >= last_row) begin
          next_row = '0;
          next_frame = ~frame_polarity_out;
        end else begin
          next_row = row_idx + 1'b1;
        end
      end
    end else if (state == ST_SLAVE) begin
      next_frame = s_level[1];
      if (cl_fall) begin
        // Frame and line clock steer the slave scan, with duty_32 setting the wrap row
        if (fr_edge || fr_pending || row_idx >= last_row) begin
          next_row = '0;
        end else begin
          next_row = row_idx + 1'b1;
        end
      end
    end
  end

  // Row counter, frame level, bias polarity and row drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_idx <= `LCD_RST_ROW;
      frame_polarity_out <= `LCD_RST_FRAME;
      drive_polarity <= `LCD_RST_FRAME;
      row_drive_outputs <= '0;
    end else begin
      row_idx <= next_row;
      frame_polarity_out <= next_frame;
      drive_polarity <= next_frame;
      row_drive_outputs <= row_bits(next_row, state == ST_SLAVE);
    end
  end

  // Pin direction and oscillator forwarding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_polarity_oe <= 1'b0;
      line_clock_oe <= 1'b0;
      oscillator_out_pin_oe <= 1'b0;
      oscillator_out_pin_out <= 1'b0;
      is_master <= 1'b0;
    end else begin
      frame_polarity_oe <= state == ST_MASTER;
      line_clock_oe <= state == ST_MASTER;
      oscillator_out_pin_oe <= state == ST_MASTER;
      oscillator_out_pin_out <= (state == ST_MASTER) & osc_in_s;
      is_master <= state == ST_MASTER;
    end
  end

  property p_master_fr_out;
    @(posedge clk) disable iff (!rst_n)
    $past(state) == ST_MASTER |-> frame_polarity_oe && line_clock_oe;
  endproperty
  a_master_fr_out: assert property (p_master_fr_out) else $error("master not driving");

  property p_slave_no_drive;
    @(posedge clk) disable iff (!rst_n)
    $past(state) == ST_SLAVE |->
      !frame_polarity_oe && !line_clock_oe && !oscillator_out_pin_oe;
  endproperty
  a_slave_no_drive: assert property (p_slave_no_drive) else $error("slave drives pin");

  // In master mode bias polarity flips only at a line step, always together with the frame
  property p_polarity_tracks_frame;
    @(posedge clk) disable iff (!rst_n)
    state == ST_MASTER && !line_fall |=>
      $stable(drive_polarity) && drive_polarity == frame_polarity_out;
  endproperty
  a_polarity_tracks_frame: assert property (p_polarity_tracks_frame)
    else $error("bias polarity off frame");

  property p_role_fixed;
    @(posedge clk) disable iff (!rst_n)
    state != ST_SETTLE |=> state == $past(state);
  endproperty
  a_role_fixed: assert property (p_role_fixed) else $error("role changed");

  property p_master_rows;
    @(posedge clk) disable iff (!rst_n)
    state == ST_MASTER && row_idx < 5'd16 |->
      row_drive_outputs == (16'h0001 << row_idx[3:0]);
  endproperty
  a_master_rows: assert property (p_master_rows) else $error("master row wrong");

  property p_slave_reverse;
    @(posedge clk) disable iff (!rst_n)
    state == ST_SLAVE && row_idx >= 5'd16 |->
      row_drive_outputs == (16'h8000 >> row_idx[3:0]);
  endproperty
  a_slave_reverse: assert property (p_slave_reverse) else $error("slave order wrong");

  property p_frame_on_wrap;
    @(posedge clk) disable iff (!rst_n)
    state == ST_MASTER && line_fall && row_idx >= last_row |=>
      frame_polarity_out != $past(frame_polarity_out) && row_idx == 5'd0;
  endproperty
  a_frame_on_wrap: assert property (p_frame_on_wrap) else $error("frame not toggled");

  property p_master_advance;
    @(posedge clk) disable iff (!rst_n)
    state == ST_MASTER && line_fall && row_idx < last_row |=>
      row_idx == $past(row_idx) + 5'd1 && $stable(frame_polarity_out);
  endproperty
  a_master_advance: assert property (p_master_advance) else $error("row not advanced");

  property p_slave_resync;
    @(posedge clk) disable iff (!rst_n)
    state == ST_SLAVE && cl_fall && (fr_edge || fr_pending) |=> row_idx == 5'd0;
  endproperty
  a_slave_resync: assert property (p_slave_resync) else $error("slave not resynced");

endmodule : lcd_master_slave_sync

// ==== rtl/lcd_sync_params.svh ====
`ifndef LCD_SYNC_PARAMS_SVH
`define LCD_SYNC_PARAMS_SVH

// Rows driven by one chip
`define LCD_ROWS_PER_CHIP 16
// Rows in a 1/16 and a 1/32 duty frame
`define LCD_DUTY16_ROWS 16
`define LCD_DUTY32_ROWS 32
// Oscillator rising edges per half period of the line clock
`define LCD_OSC_PER_HALF_LINE 4
// Cycles the synchronised strap must settle before it is captured
`define LCD_STRAP_SETTLE 3
// Synchroniser stages ahead of any pin logic
`define LCD_SYNC_STAGES 2
// Reset values
`define LCD_RST_ROW 5'h00
`define LCD_RST_FRAME 1'h0

`endif

// ==== rtl/lcd_sync_pkg.sv ====
package lcd_sync_pkg;

  // Role of the chip, fixed once after reset
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_MASTER,
    ST_SLAVE
  } role_state_t;

  // Row counter across the whole panel
  typedef logic [4:0] row_index_t;

endpackage : lcd_sync_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps

// Two-stage synchroniser with edge detection behind the second stage
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pins
  input wire logic [WIDTH-1:0] pin,
  // Synchronised level and one-cycle edge pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;
  logic [2:0] warm;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      level <= '0;
      last <= '0;
      warm <= '0;
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
      warm <= {warm[1:0], 1'b1};
    end
  end

  // Edges held off until last holds a real pin level; a high pin gives no false edge
  assign rise = level & ~last & {WIDTH{warm[2]}};
  assign fall = ~level & last & {WIDTH{warm[2]}};

endmodule : pin_sync

// ==== tb/lcd_far_side.sv ====
`timescale 1ns/1ps

// Far-side master chip feeding a slave under test
module lcd_far_side #(
  parameter int ROWS = 32
) (
  // Control
  input wire logic run,
  // Link pins
  output logic line_clock,
  output logic frame_polarity,
  // Panel row selected now
  output logic [4:0] row
);
  // Own timing, unrelated in phase to the bench clock
  initial begin
    line_clock = 1'h0;
    frame_polarity = 1'h0;
    row = 5'h00;
    #137;
    forever begin
      #400;
      if (run) begin
        line_clock = ~line_clock;
        // Row steps on the fall; frame flips with the wrap
        if (!line_clock) begin
          row = (row == 5'(ROWS - 1)) ? 5'h00 : row + 5'h01;
          if (row == 5'h00) frame_polarity = ~frame_polarity;
        end
      end
    end
  end
endmodule : lcd_far_side

// ==== tb/lcd_master_slave_sync_tb.sv ====
`timescale 1ns/1ps

module lcd_master_slave_sync_tb;
  import lcd_sync_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic master_strap = 1'h0;
  logic duty_32 = 1'h0;
  logic osc = 1'h0;
  logic [1:0] osc_div = 2'h0;
  logic far_run = 1'h0;
  logic far_line, far_frame;
  logic [4:0] far_row;
  logic osc_out, osc_oe, fr_out, fr_oe, lc_out, lc_oe, drive_polarity, is_master;
  logic [15:0] row_drive_outputs;
  logic [1:0] osc_seen;
  int failures = 0;
  int samples_checked = 0;
  // Pin levels resolved from the chip's enables; otherwise the far side or osc drives
  wire logic fr_pin = fr_oe ? fr_out : far_frame;
  wire logic lc_pin = lc_oe ? lc_out : far_line;
  wire logic osc_pin = osc_oe ? osc_out : osc;

  // No chip select pin: address decoding stays with the host
  // Short counts keep frames brief
  lcd_master_slave_sync #(.OSC_PER_HALF_LINE(1), .STRAP_SETTLE(1)) i_lcd_master_slave_sync (
    .clk(clk), .rst_n(rst_n), .master_strap(master_strap), .duty_32(duty_32),
    .oscillator_in_pin(osc), .oscillator_out_pin_in(osc_pin),
    .oscillator_out_pin_out(osc_out), .oscillator_out_pin_oe(osc_oe),
    .frame_polarity_in(fr_pin), .frame_polarity_out(fr_out), .frame_polarity_oe(fr_oe),
    .line_clock_in(lc_pin), .line_clock_out(lc_out), .line_clock_oe(lc_oe),
    .row_drive_outputs(row_drive_outputs), .drive_polarity(drive_polarity),
    .is_master(is_master));

  lcd_far_side #(.ROWS(32)) i_lcd_far_side (
    .run(far_run), .line_clock(far_line), .frame_polarity(far_frame), .row(far_row));

  // Clock and an oscillator of 8 clock periods
  always #50 clk = ~clk;
  always @(posedge clk) begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3) osc <= #10 ~osc;
  end

  task finish_test;
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Reset with strap and duty set; all outputs low meanwhile
  task do_reset(input logic strap, input logic d32);
    @(posedge clk);
    #10 rst_n = 1'h0;
    master_strap = strap;
    duty_32 = d32;
    far_run = 1'h0;
    repeat (2) @(posedge clk);
    #1 chk(row_drive_outputs, 16'h0000);
    chk(16'({is_master, fr_oe, lc_oe, osc_oe, fr_out, lc_out, osc_out, drive_polarity}), 16'h0000);
    #9 rst_n = 1'h1;
    repeat (12) @(posedge clk);
    #1;
  endtask : do_reset

  // Bounded wait for a fall of the line clock pin
  task wait_fall;
    logic prev;
    int n;
    prev = lc_pin;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1 osc_seen = osc_seen | {osc_out, ~osc_out};
      if (prev === 1'h1 && lc_pin === 1'h0) break;
      prev = lc_pin;
    end
    if (n == 40) begin
      failures++;
      $display("ERROR %0t line clock stalled", $time);
      finish_test();
    end
  endtask : wait_fall

  // Master: pins driven, rows stepped, frame flips at wrap, strap ignored later
  task test_master(input logic d32);
    int k;
    int rows;
    logic [4:0] idx;
    logic f;
    rows = d32 ? 32 : 16;
    do_reset(1'h1, d32);
    chk(16'({is_master, fr_oe, lc_oe, osc_oe}), 16'h000F);
    chk(row_drive_outputs, 16'h0001);
    #9 master_strap = 1'h0;
    osc_seen = 2'h0;
    for (k = 1; k <= rows + 3; k++) begin
      wait_fall();
      repeat (2) @(posedge clk);
      #1 idx = 5'(k % rows);
      f = 1'((k / rows) % 2);
      chk(row_drive_outputs, idx < 5'd16 ? 16'h0001 << idx : 16'h0000);
      chk(16'({fr_out, drive_polarity, is_master}), 16'({f, f, 1'h1}));
    end
    chk(16'(osc_seen), 16'h0003);
  endtask : test_master

  // Slave: pins released, rows follow the far master in reverse order
  task test_slave;
    int k;
    do_reset(1'h0, 1'h1);
    chk(16'({is_master, fr_oe, lc_oe, osc_oe, lc_out, osc_out}), 16'h0000);
    far_run = 1'h1;
    for (k = 0; k < 40 && far_frame !== 1'h1; k++) wait_fall();
    for (k = 0; k < 36; k++) begin
      wait_fall();
      repeat (5) @(posedge clk);
      #1 chk(row_drive_outputs,
             far_row > 5'd15 ? 16'h0001 << (5'd31 - far_row) : 16'h0000);
      chk(16'({fr_out, drive_polarity}), 16'({far_frame, far_frame}));
    end
  endtask : test_slave

  initial begin
    test_master(1'h0);
    test_master(1'h1);
    test_slave();
    finish_test();
  end
endmodule : lcd_master_slave_sync_tb
